//--- verilog/hbad_pkg.sv
// constants shared by both ends of the host bus address decode front end
// assumes one 50 mhz clock on both ends
package hbad_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int SEL_W = 3;
  localparam int SEL_LSB = 1;
  localparam int SEL_MSB = 3;
  localparam int DEC_LSB = 4;
  localparam int DEC_MSB = 15;
  localparam int CLK_PERIOD_NS = 20;
  localparam int RST_FILT_NS = 100;
  localparam int RST_FILT_CYC = (RST_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_HOLD_CYC = RST_FILT_CYC + 2;
  localparam logic [15:0] BASE_RST = 16'h0300;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_FILT = 4'(RST_FILT_CYC);
  localparam logic [3:0] CNT_HOLD = 4'(RST_HOLD_CYC);
  localparam logic [31:0] BUS_IDLE = 32'hffffffff;
  localparam logic [3:0] LANES_ALL = 4'hf;
  localparam logic [3:0] LANES_HI_OFF = 4'hc;
  localparam logic [2:0] BYTES_FULL = 3'h4;
endpackage

//--- verilog/hbad_if.sv
// pin level carrier between host bus master and device decode front end
// data lines resolve from the two enables, idle high through weak pull-ups
`timescale 1ns/1ps
`default_nettype none
interface hbad_if;
  logic [15:1] addr;
  logic address_qualifier_low;
  logic [3:0] byte_lane_enables_n;
  logic data_path_select_n;
  logic address_latch_strobe_n;
  logic burst_cycle_control_n;
  logic cycle_direction;
  logic host_reset;
  logic local_device_select_n;
  logic [31:0] host_data;
  logic host_data_oe;
  logic [31:0] dev_data;
  logic dev_data_oe;
  logic [31:0] data_bus;

  // pull-ups win when nobody drives
  assign data_bus = dev_data_oe ? dev_data : (host_data_oe ? host_data : hbad_pkg::BUS_IDLE);

  modport dev (
    input addr, address_qualifier_low, byte_lane_enables_n, data_path_select_n,
    input address_latch_strobe_n, burst_cycle_control_n, cycle_direction, host_reset,
    input data_bus,
    output local_device_select_n, dev_data, dev_data_oe
  );
  modport host (
    output addr, address_qualifier_low, byte_lane_enables_n, data_path_select_n,
    output address_latch_strobe_n, burst_cycle_control_n, cycle_direction, host_reset,
    output host_data, host_data_oe,
    input data_bus, local_device_select_n
  );
endinterface
`default_nettype wire

//--- verilog/hbad_device.sv
// device end: address decode, register select, lane sizing, reset filter
// assumes all pins synchronous to i_clk and a host that keeps its side
//
// Overview of operation
// RQ1 - decode address bits 4..15 for device hit
// RQ2 - address bits 1..3 choose internal register
// RQ3 - decode only while qualifier input is low
// RQ4 - byte lane enables give width and bytes
// RQ5 - burst select forces full 32-bit lanes
// RQ6 - 32-bit two-way data bus, pulled up
// RQ7 - 16-bit hosts use only lower lines
// RQ8 - filtered reset returns everything to defaults
// RQ9 - after reset request configuration load
// RQ10 - reset accepted only after 100ns high
// RQ11 - strobe rising edge latches address, qualifier
// RQ12 - select decode uses unlatched, others latched
// RQ13 - burst cycle control frames synchronous cycles
// RQ14 - direction high write, low read
// RQ15 - select output on qualifier and base match
// RQ16 - drive data only during decoded read
`timescale 1ns/1ps
`default_nettype none
module hbad_device (
  input wire logic i_clk,
  input wire logic i_rst,
  hbad_if.dev bus,
  input wire logic i_addr_latch_en,
  input wire logic i_base_wr,
  input wire logic [15:0] i_base_data,
  input wire logic [31:0] i_rd_data,
  output logic o_sys_reset,
  output logic o_config_load,
  output logic o_hit,
  output logic [2:0] o_reg_sel,
  output logic [3:0] o_lanes,
  output logic [2:0] o_bytes,
  output logic o_rd_stb,
  output logic o_wr_stb,
  output logic [31:0] o_wr_data,
  output logic [15:0] o_base
);

  //--------------------------------------------------------------
  // reset glitch filter
  //--------------------------------------------------------------
  logic [3:0] rst_cnt_q;
  logic [3:0] rst_cnt_d;
  logic sys_reset_q;
  logic sys_reset_d;
  logic config_load_q;
  logic config_load_d;

  assign rst_cnt_d = !bus.host_reset ? hbad_pkg::CNT_ZERO :
                     (rst_cnt_q == hbad_pkg::CNT_FILT) ? rst_cnt_q : rst_cnt_q + 4'h1; // RQ10
  assign sys_reset_d = bus.host_reset && (rst_cnt_d == hbad_pkg::CNT_FILT); // RQ10
  // one pulse when the filtered reset lets go
  assign config_load_d = sys_reset_q && !sys_reset_d; // RQ9

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rst_cnt_q <= hbad_pkg::CNT_ZERO;
      sys_reset_q <= 1'b0;
      config_load_q <= 1'b0;
    end else begin
      rst_cnt_q <= rst_cnt_d;
      sys_reset_q <= sys_reset_d;
      config_load_q <= config_load_d;
    end
  end

  //--------------------------------------------------------------
  // base address register
  //--------------------------------------------------------------
  logic [15:0] base_q;
  logic [15:0] base_d;

  assign base_d = sys_reset_q ? hbad_pkg::BASE_RST : // RQ8
                  i_base_wr ? i_base_data : base_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      base_q <= hbad_pkg::BASE_RST;
    end else begin
      base_q <= base_d;
    end
  end

  //--------------------------------------------------------------
  // address latch on strobe rising edge
  //--------------------------------------------------------------
  logic strobe_prev_q;
  logic strobe_rise;
  logic [15:1] addr_lat_q;
  logic [15:1] addr_lat_d;
  logic qual_lat_q;
  logic qual_lat_d;

  assign strobe_rise = bus.address_latch_strobe_n && !strobe_prev_q; // RQ11
  assign addr_lat_d = strobe_rise ? bus.addr : addr_lat_q; // RQ11
  assign qual_lat_d = strobe_rise ? bus.address_qualifier_low : qual_lat_q; // RQ11

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      strobe_prev_q <= 1'b1;
      addr_lat_q <= 15'h7fff;
      qual_lat_q <= 1'b1;
    end else if (sys_reset_q) begin
      strobe_prev_q <= 1'b1;
      addr_lat_q <= 15'h7fff;
      qual_lat_q <= 1'b1;
    end else begin
      strobe_prev_q <= bus.address_latch_strobe_n;
      addr_lat_q <= addr_lat_d;
      qual_lat_q <= qual_lat_d;
    end
  end

  //--------------------------------------------------------------
  // decode
  //--------------------------------------------------------------
  logic [15:1] addr_use;
  logic qual_use;
  logic hit_w;
  logic sel_live_w;
  logic [2:0] reg_sel_w;

  // internal functions take the latched copy when latching is on,
  // the value being captured already at the latching edge so that
  // register select is settled before the read data is sampled
  assign addr_use = i_addr_latch_en ? addr_lat_d : bus.addr; // RQ12
  assign qual_use = i_addr_latch_en ? qual_lat_d : bus.address_qualifier_low; // RQ12
  assign hit_w = !qual_use && (addr_use[15:4] == base_q[15:4]); // RQ1 RQ3
  assign reg_sel_w = addr_use[3:1]; // RQ2
  // local select always sees the live pins
  assign sel_live_w = !bus.address_qualifier_low && (bus.addr[15:4] == base_q[15:4]); // RQ15 RQ12 RQ3

  //--------------------------------------------------------------
  // byte lane sizing
  //--------------------------------------------------------------
  logic [3:0] lanes_w;
  logic [2:0] bytes_w;
  logic burst_w;

  assign burst_w = !bus.data_path_select_n;
  genvar g;
  generate
    for (g = 0; g < hbad_pkg::LANES; g++) begin : g_lane
      assign lanes_w[g] = burst_w ? 1'b1 : !bus.byte_lane_enables_n[g]; // RQ4 RQ5
    end
  endgenerate
  assign bytes_w = burst_w ? hbad_pkg::BYTES_FULL : // RQ5
                   3'({2'b00, lanes_w[0]}) + 3'({2'b00, lanes_w[1]}) +
                   3'({2'b00, lanes_w[2]}) + 3'({2'b00, lanes_w[3]}); // RQ4

  //--------------------------------------------------------------
  // synchronous cycle control
  //--------------------------------------------------------------
  logic cycle_w;
  logic rd_cond;
  logic wr_cond;
  logic [31:0] wr_data_d;

  assign cycle_w = !bus.burst_cycle_control_n && !sys_reset_q; // RQ13
  assign rd_cond = hit_w && cycle_w && !bus.cycle_direction; // RQ14
  assign wr_cond = hit_w && cycle_w && bus.cycle_direction; // RQ14
  generate
    for (g = 0; g < hbad_pkg::LANES; g++) begin : g_wbyte
      // only enabled lanes take bus data
      assign wr_data_d[g*8 +: 8] = (wr_cond && lanes_w[g]) ? bus.data_bus[g*8 +: 8] : o_wr_data[g*8 +: 8]; // RQ4 RQ6
    end
  endgenerate

  //--------------------------------------------------------------
  // output registers
  //--------------------------------------------------------------
  logic ldev_n_q;
  logic dev_oe_q;
  logic [31:0] dev_data_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ldev_n_q <= 1'b1;
      dev_oe_q <= 1'b0;
      dev_data_q <= 32'h00000000;
      o_hit <= 1'b0;
      o_reg_sel <= 3'h0;
      o_lanes <= 4'h0;
      o_bytes <= 3'h0;
      o_rd_stb <= 1'b0;
      o_wr_stb <= 1'b0;
      o_wr_data <= 32'h00000000;
    end else if (sys_reset_q) begin
      ldev_n_q <= 1'b1; // RQ8
      dev_oe_q <= 1'b0; // RQ8
      dev_data_q <= 32'h00000000;
      o_hit <= 1'b0;
      o_reg_sel <= 3'h0;
      o_lanes <= 4'h0;
      o_bytes <= 3'h0;
      o_rd_stb <= 1'b0;
      o_wr_stb <= 1'b0;
      o_wr_data <= 32'h00000000;
    end else begin
      ldev_n_q <= !sel_live_w; // RQ15
      dev_oe_q <= rd_cond; // RQ16 RQ6
      dev_data_q <= i_rd_data;
      o_hit <= hit_w; // RQ1
      o_reg_sel <= reg_sel_w; // RQ2
      o_lanes <= lanes_w; // RQ4
      o_bytes <= bytes_w; // RQ4
      o_rd_stb <= rd_cond; // RQ14
      o_wr_stb <= wr_cond; // RQ14
      o_wr_data <= wr_data_d;
    end
  end

  assign bus.local_device_select_n = ldev_n_q;
  assign bus.dev_data_oe = dev_oe_q;
  assign bus.dev_data = dev_data_q;
  assign o_sys_reset = sys_reset_q;
  assign o_config_load = config_load_q;
  assign o_base = base_q;

endmodule // hbad_device
`default_nettype wire

//--- verilog/hbad_host.sv
// host end: single synchronous cycle master and reset driver
// assumes the device samples pins on the same i_clk
`timescale 1ns/1ps
`default_nettype none
module hbad_host (
  input wire logic i_clk,
  input wire logic i_rst,
  hbad_if.host bus,
  input wire logic i_req,
  input wire logic i_write,
  input wire logic [15:1] i_addr,
  input wire logic [3:0] i_lanes_n,
  input wire logic i_burst,
  input wire logic [31:0] i_wdata,
  input wire logic i_bus16,
  input wire logic i_reset_req,
  output logic o_busy,
  output logic o_done,
  output logic [31:0] o_rdata
);

  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_LATCH, S_CYC, S_SAMPLE, S_RESET} hbad_state_t;
  hbad_state_t state_q;
  hbad_state_t state_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [15:1] addr_q;
  logic write_q;
  logic burst_q;
  logic [3:0] lanes_n_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_w;

  //--------------------------------------------------------------
  // sequencing
  //--------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      S_IDLE: begin
        if (i_reset_req) begin
          state_d = S_RESET;
          cnt_d = hbad_pkg::CNT_ZERO;
        end else if (i_req) begin
          state_d = S_ADDR;
        end
      end
      S_ADDR: state_d = S_LATCH;
      S_LATCH: state_d = S_CYC;
      S_CYC: state_d = S_SAMPLE;
      S_SAMPLE: state_d = S_IDLE;
      S_RESET: begin
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == hbad_pkg::CNT_HOLD) begin
          state_d = S_IDLE; // RQ10
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  // 16-bit hosts keep the upper lines and lanes out of use
  assign rdata_w = i_bus16 ? {16'h0000, bus.data_bus[15:0]} : bus.data_bus; // RQ7

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= S_IDLE;
      cnt_q <= hbad_pkg::CNT_ZERO;
      addr_q <= 15'h7fff;
      write_q <= 1'b0;
      burst_q <= 1'b0;
      lanes_n_q <= hbad_pkg::LANES_ALL;
      wdata_q <= 32'h00000000;
      o_done <= 1'b0;
      o_rdata <= 32'h00000000;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      o_done <= (state_q == S_SAMPLE);
      if (state_q == S_IDLE && i_req && !i_reset_req) begin
        addr_q <= i_addr;
        write_q <= i_write;
        burst_q <= i_burst && !i_bus16;
        lanes_n_q <= i_bus16 ? (i_lanes_n | hbad_pkg::LANES_HI_OFF) : i_lanes_n; // RQ7 RQ4
        wdata_q <= i_bus16 ? {16'h0000, i_wdata[15:0]} : i_wdata; // RQ7
      end
      if (state_q == S_SAMPLE && !write_q) begin
        o_rdata <= rdata_w;
      end
    end
  end

  //--------------------------------------------------------------
  // pin drive
  //--------------------------------------------------------------
  logic in_cycle;
  assign in_cycle = (state_q == S_ADDR) || (state_q == S_LATCH) ||
                    (state_q == S_CYC) || (state_q == S_SAMPLE);
  assign bus.addr = addr_q;
  assign bus.address_qualifier_low = !in_cycle; // RQ3
  assign bus.address_latch_strobe_n = (state_q != S_ADDR);
  assign bus.burst_cycle_control_n = (state_q != S_CYC); // RQ13
  assign bus.cycle_direction = write_q; // RQ14
  assign bus.byte_lane_enables_n = in_cycle ? lanes_n_q : hbad_pkg::LANES_ALL; // RQ4
  assign bus.data_path_select_n = !(in_cycle && burst_q);
  assign bus.host_data = wdata_q;
  assign bus.host_data_oe = in_cycle && write_q;
  assign bus.host_reset = (state_q == S_RESET); // RQ10
  assign o_busy = (state_q != S_IDLE);

endmodule // hbad_host
`default_nettype wire

//--- testbench/hbad_pins_sva.sv
// assertions on the pins between host and device ends
// assumes one clock and an asynchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module hbad_pins_sva (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic address_qualifier_low,
  input wire logic address_latch_strobe_n,
  input wire logic burst_cycle_control_n,
  input wire logic cycle_direction,
  input wire logic host_reset,
  input wire logic local_device_select_n,
  input wire logic host_data_oe,
  input wire logic dev_data_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_one_drv; !(host_data_oe && dev_data_oe); endproperty
  a_one_drv: assert property (p_one_drv)
    else $error("both ends drive data");
  property p_rd_drv; dev_data_oe |-> $past(!burst_cycle_control_n && !cycle_direction); endproperty
  a_rd_drv: assert property (p_rd_drv)
    else $error("device drives outside read");
  property p_hit_drv; $fell(burst_cycle_control_n) && !cycle_direction && !local_device_select_n |=> dev_data_oe;
  endproperty
  a_hit_drv: assert property (p_hit_drv)
    else $error("decoded read not driven");
  property p_sel_qual; !local_device_select_n |-> $past(!address_qualifier_low); endproperty
  a_sel_qual: assert property (p_sel_qual)
    else $error("select without qualifier");
  property p_stb; $fell(address_latch_strobe_n) |-> (!address_qualifier_low)[*3] ##0 address_latch_strobe_n;
  endproperty
  a_stb: assert property (p_stb)
    else $error("qualifier not held");
  property p_cyc; $fell(burst_cycle_control_n) |-> $past(address_latch_strobe_n) && !$past(address_latch_strobe_n, 2);
  endproperty
  a_cyc: assert property (p_cyc)
    else $error("cycle not after latch");
  property p_cyc1; !burst_cycle_control_n |=> burst_cycle_control_n; endproperty
  a_cyc1: assert property (p_cyc1)
    else $error("cycle too long");
  property p_dir; !burst_cycle_control_n |-> host_data_oe == cycle_direction; endproperty
  a_dir: assert property (p_dir)
    else $error("direction and drive differ");
  property p_rst; $rose(host_reset) |-> host_reset[*8]; endproperty
  a_rst: assert property (p_rst)
    else $error("reset too short");
endmodule // hbad_pins_sva
`default_nettype wire

//--- testbench/tb.sv
// self-checking bench joining host and device ends over the pin carrier
// assumes 50 mhz clock and reset high for 5 cycles at start
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct {logic wr; logic [2:0] sel; logic [3:0] lanes; logic [31:0] data;} hbad_exp_t;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic req = 1'b0, wr = 1'b0, burst = 1'b0, bus16 = 1'b0, rst_req = 1'b0, latch_en = 1'b0, base_wr = 1'b0;
  logic [15:1] addr = 15'h0000;
  logic [3:0] lanes_n = 4'hf;
  logic [31:0] wdata = 32'h0, rd_pat = 32'h0, shadow = 32'h0, rd_exp = 32'h0, rd_mask = 32'h0;
  logic [15:0] base_data = 16'h0, base = hbad_pkg::BASE_RST;
  logic rd_pend = 1'b0;
  logic sys_reset, cfg_load, hit, rd_stb, wr_stb, busy, done;
  logic [2:0] reg_sel, bytes;
  logic [3:0] lanes;
  logic [31:0] wr_data, rdata;
  logic [15:0] base_q;
  wire logic [31:0] rd_data = rd_pat ^ {29'h0, reg_sel};
  int err_total = 0, tests_run = 0;
  hbad_exp_t expq[$];
  hbad_if bus();
  hbad_device u_hbad_device (.i_clk(i_clk), .i_rst(i_rst), .bus(bus), .i_addr_latch_en(latch_en), .i_base_wr(base_wr),
    .i_base_data(base_data), .i_rd_data(rd_data), .o_sys_reset(sys_reset), .o_config_load(cfg_load), .o_hit(hit),
    .o_reg_sel(reg_sel), .o_lanes(lanes), .o_bytes(bytes), .o_rd_stb(rd_stb), .o_wr_stb(wr_stb), .o_wr_data(wr_data),
    .o_base(base_q));
  hbad_host u_hbad_host (.i_clk(i_clk), .i_rst(i_rst), .bus(bus), .i_req(req), .i_write(wr), .i_addr(addr),
    .i_lanes_n(lanes_n), .i_burst(burst), .i_wdata(wdata), .i_bus16(bus16), .i_reset_req(rst_req), .o_busy(busy),
    .o_done(done), .o_rdata(rdata));
  hbad_pins_sva u_hbad_pins_sva (.i_clk(i_clk), .i_rst(i_rst), .address_qualifier_low(bus.address_qualifier_low),
    .address_latch_strobe_n(bus.address_latch_strobe_n), .burst_cycle_control_n(bus.burst_cycle_control_n),
    .cycle_direction(bus.cycle_direction), .host_reset(bus.host_reset),
    .local_device_select_n(bus.local_device_select_n), .host_data_oe(bus.host_data_oe),
    .dev_data_oe(bus.dev_data_oe));
  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [31:0] lmask(input logic [3:0] l);
    lmask = {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
  endfunction
  function automatic logic [31:0] nbytes(input logic [3:0] l);
    nbytes = 32'(l[0]) + 32'(l[1]) + 32'(l[2]) + 32'(l[3]);
  endfunction
  task automatic xfer(input logic w, input logic [15:1] a, input logic [3:0] ln, input logic b, input logic b16);
    hbad_exp_t e;
    logic seen;
    int n;
    e.wr = w;
    e.sel = a[3:1];
    e.lanes = b16 ? (~ln & 4'h3) : (b ? hbad_pkg::LANES_ALL : ~ln);
    e.data = $urandom();
    seen = 1'b0;
    if (a[15:4] == base[15:4]) expq.push_back(e);
    @(negedge i_clk);
    {req, wr, addr, lanes_n, burst, bus16, wdata, rd_pat} = {1'b1, w, a, ln, b, b16, e.data, e.data};
    @(negedge i_clk);
    req = 1'b0;
    for (n = 0; n < 20 && done !== 1'b1; n++) begin
      seen |= (bus.local_device_select_n === 1'b0);
      if (bus.burst_cycle_control_n === 1'b0) chk("hit at cycle", {31'h0, a[15:4] == base[15:4]}, {31'h0, hit});
      @(negedge i_clk);
    end
    chk("done", 32'h1, {31'h0, done});
    chk("select", {31'h0, a[15:4] == base[15:4]}, {31'h0, seen});
    @(negedge i_clk);
  endtask
  // --------------------------------------------------------------------
  // result watcher
  // --------------------------------------------------------------------
  always @(negedge i_clk) begin
    hbad_exp_t e;
    if (rd_stb === 1'b1 || wr_stb === 1'b1) begin
      if (expq.size() == 0) chk("stray strobe", 32'h0, 32'h1);
      else begin
        e = expq.pop_front();
        chk("dir", {31'h0, e.wr}, {31'h0, wr_stb});
        chk("sel", {29'h0, e.sel}, {29'h0, reg_sel});
        chk("lanes", {28'h0, e.lanes}, {28'h0, lanes});
        chk("bytes", nbytes(e.lanes), {29'h0, bytes});
        chk("hit", 32'h1, {31'h0, hit});
        if (e.wr) begin
          shadow = (shadow & ~lmask(e.lanes)) | (e.data & lmask(e.lanes));
          chk("wr_data", shadow, wr_data);
        end else begin
          rd_exp = (e.data ^ {29'h0, e.sel}) & lmask(e.lanes);
          rd_mask = lmask(e.lanes);
          rd_pend = 1'b1;
        end
      end
    end
    if (done === 1'b1 && rd_pend) begin
      chk("rdata", rd_exp, rdata & rd_mask);
      rd_pend = 1'b0;
    end
  end
  initial begin
    forever #10 i_clk = ~i_clk;
  end
  initial begin
    #200000;
    err_total++;
    report_and_stop();
  end
  initial begin
    int i;
    int n;
    logic [15:1] a;
    void'($urandom(32'h38d8695e));
    repeat (5) @(negedge i_clk);
    i_rst = 1'b0;
    for (i = 0; i < 30; i++) begin
      if (i == 20) begin
        {base_wr, base_data} = {1'b1, 16'h0340};
        @(negedge i_clk);
        base_wr = 1'b0;
        base = 16'h0340;
        @(negedge i_clk);
        chk("base", {16'h0, base}, {16'h0, base_q});
      end
      latch_en = i[0];
      a = 15'($urandom());
      if (i % 4 != 3) a[15:4] = base[15:4];
      if (i % 5 == 4) xfer(i[1], a, 4'hc | 4'($urandom_range(2, 0)), i[2], 1'b1);
      else xfer(i[1], a, 4'($urandom_range(14, 0)), i[2], 1'b0);
    end
    rst_req = 1'b1;
    @(negedge i_clk);
    rst_req = 1'b0;
    for (n = 0; n < 20 && bus.host_reset !== 1'b1; n++) @(negedge i_clk);
    for (n = 0; n < 20 && sys_reset !== 1'b1; n++) @(negedge i_clk);
    chk("filter", 32'h1, {31'h0, n >= hbad_pkg::RST_FILT_CYC - 1 && n <= hbad_pkg::RST_FILT_CYC});
    for (n = 0; n < 20 && cfg_load !== 1'b1; n++) @(negedge i_clk);
    chk("config load", 32'h1, {31'h0, cfg_load});
    chk("base default", {16'h0, hbad_pkg::BASE_RST}, {16'h0, base_q});
    {base, shadow} = {hbad_pkg::BASE_RST, 32'h0};
    for (n = 0; n < 20 && busy !== 1'b0; n++) @(negedge i_clk);
    chk("busy", 32'h0, {31'h0, busy});
    xfer(1'b1, {base[15:4], 3'h5}, 4'h0, 1'b0, 1'b0);
    xfer(1'b0, {base[15:4], 3'h5}, 4'h0, 1'b1, 1'b0);
    chk("pending results", 32'h0, 32'(expq.size()));
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
